// [core/sadc_pkg.sv]
// Shared constants and types of the serial converter link
package sadc_pkg;
    localparam int RES_BITS = 10;
    localparam int ADDR_BITS = 4;
    localparam int XFER_MIN = 10;
    localparam int XFER_MAX = 16;
    localparam int BYTE_CLKS = 8;
    localparam int CONV_FALL = 10;
    localparam int ACQ_CLKS = 6;
    localparam int ACQ_START_FALL = CONV_FALL - ACQ_CLKS;
    localparam int CNT_W = 5;
    localparam int CLK_PERIOD_NS = 20;
    // Longest times round down, least times round up
    localparam int CONV_MAX_NS = 44000;
    localparam int CONV_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int ABORT_MAX_NS = 9000;
    localparam int ABORT_CYC = ABORT_MAX_NS / CLK_PERIOD_NS;
    localparam int RISE_MAX_NS = 18500;
    localparam int RISE_CYC = RISE_MAX_NS / CLK_PERIOD_NS;
    localparam int SCLK_MIN_PERIOD_NS = 477;
    localparam int SCLK_HALF_CYC =
        (SCLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    localparam int CS_SETUP_NS = 2425;
    localparam int CS_SETUP_CYC =
        (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EOC_GUARD_CYC = 8;
    localparam int TMR_W = 12;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        SADC_CV_IDLE = 2'b00,
        SADC_CV_RUN = 2'b01,
        SADC_CV_PEND = 2'b10
    } sadc_conv_t;

    typedef enum logic [2:0] {
        SADC_H_IDLE = 3'b000,
        SADC_H_SETUP = 3'b001,
        SADC_H_LOW = 3'b010,
        SADC_H_HIGH = 3'b011,
        SADC_H_END = 3'b100,
        SADC_H_WAIT = 3'b101,
        SADC_H_ABORT = 3'b110
    } sadc_host_t;
endpackage : sadc_pkg

// [core/sadc_if.sv]
// Pin bundle between converter end and host end
`timescale 1ns/10ps
`default_nettype none
interface sadc_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout;
    logic dout_oe;
    logic eoc;
    wire dout_line;

    // Released data line rests high, as a pull-up would hold it
    assign dout_line = dout_oe ? dout : 1'b1;

    modport dev (
        input cs_n,
        input sclk,
        input din,
        output dout,
        output dout_oe,
        output eoc
    );

    modport host (
        output cs_n,
        output sclk,
        output din,
        input dout_line,
        input eoc
    );
endinterface : sadc_if
`default_nettype wire

// [core/sadc_dev.sv]
// Converter end: serial port, acquisition window and conversion sequencer
//
// Functional notes
// - Each result is a 10-bit unsigned code
// - Conversion finishes within 44 us, own timing
// - A transfer is 10 to 16 clocks
// - Acquisition window lasts six shift clocks
// - Host shift clock at most 2.1 MHz
// - Long transfers need a rise within 18.5 us
// - Select fall during conversion aborts it
// - Select may change right after done edge
// - Select held low: only 10 or 16 clocks
// - 16 clocks accepted continuous or as bytes
// - Address captured MSB first, first four rises
// - Result MSB first, one bit per fall, zeros
// - Done low at tenth fall, high when ready
// - Select high: output released, port inert
`timescale 1ns/10ps
`default_nettype none
module sadc_dev #(
    parameter int CONV_CYC = sadc_pkg::CONV_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    sadc_if.dev link,
    input wire logic [sadc_pkg::RES_BITS-1:0] code_in,
    output logic [sadc_pkg::ADDR_BITS-1:0] addr_out,
    output logic sample_on,
    output logic [sadc_pkg::RES_BITS-1:0] result_out,
    output logic result_stb
);
    localparam int RB = sadc_pkg::RES_BITS;
    localparam int CW = sadc_pkg::CNT_W;
    localparam int STEP_CYC = CONV_CYC / RB;
    localparam logic [CW-1:0] FALL_TEN = CW'(sadc_pkg::CONV_FALL);
    localparam logic [CW-1:0] FALL_ACQ = CW'(sadc_pkg::ACQ_START_FALL);
    localparam logic [CW-1:0] CNT_MAX = CW'(sadc_pkg::XFER_MAX);
    localparam logic [CW-1:0] ADDR_RISES = CW'(sadc_pkg::ADDR_BITS);
    localparam logic [11:0] CONV_LAST = 12'(CONV_CYC - 1);
    localparam logic [11:0] STEP_LAST = 12'(STEP_CYC - 1);

    if (CONV_CYC < RB || CONV_CYC > sadc_pkg::CONV_CYC || CONV_CYC > 4095)
    begin : g_bad_conv
        $error("sadc_dev: CONV_CYC out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
    logic ck_s1_reg, ck_s2_reg, ck_s3_reg;
    logic din_s1_reg, din_s2_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            ck_s1_reg <= 1'b0;
            ck_s2_reg <= 1'b0;
            ck_s3_reg <= 1'b0;
            din_s1_reg <= 1'b0;
            din_s2_reg <= 1'b0;
        end else begin
            cs_s1_reg <= link.cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            ck_s1_reg <= link.sclk;
            ck_s2_reg <= ck_s1_reg;
            ck_s3_reg <= ck_s2_reg;
            din_s1_reg <= link.din;
            din_s2_reg <= din_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge decode and sequencing terms
    sadc_pkg::sadc_conv_t cv_reg;
    logic [CW-1:0] fall_cnt_reg, rise_cnt_reg;
    logic [RB-1:0] out_sr_reg, held_reg, sar_reg, mask_reg;
    logic [11:0] conv_cnt_reg, step_cnt_reg;
    logic eoc_reg, oe_reg;

    wire cs_low = ~cs_s2_reg;
    wire cs_fall = cs_s3_reg & ~cs_s2_reg;
    // Clock and data are dead while deselected
    wire sck_rise = cs_low & ~ck_s3_reg & ck_s2_reg;
    wire sck_fall = cs_low & ck_s3_reg & ~ck_s2_reg;
    wire fall_take = sck_fall & (fall_cnt_reg < CNT_MAX);
    wire rise_take = sck_rise & (rise_cnt_reg < CNT_MAX);
    wire ten_fall = fall_take & (fall_cnt_reg == FALL_TEN - 1'b1)
        & (cv_reg == sadc_pkg::SADC_CV_IDLE);
    wire acq_fall = fall_take & (fall_cnt_reg == FALL_ACQ - 1'b1);
    wire addr_rise = rise_take & (rise_cnt_reg < ADDR_RISES);
    wire running = (cv_reg == sadc_pkg::SADC_CV_RUN);
    wire abort_hit = running & cs_fall;
    wire conv_end = running & ~cs_fall & (conv_cnt_reg == CONV_LAST);
    wire step_tick = running & (step_cnt_reg == STEP_LAST);
    wire [RB-1:0] sar_try = sar_reg | mask_reg;
    wire [RB-1:0] sar_next = (step_tick && sar_try <= held_reg)
        ? sar_try : sar_reg;
    // A rise after the tenth marks a long transfer; without one the
    // transfer was ten clocks and the port rearms at conversion end
    wire long_xfer = rise_cnt_reg > FALL_TEN;
    wire rearm_end = conv_end & cs_low
        & (~long_xfer | (fall_cnt_reg == CNT_MAX));
    wire pend_end = conv_end & cs_low & ~rearm_end;
    wire rearm_16 = (cv_reg == sadc_pkg::SADC_CV_PEND) & fall_take
        & (fall_cnt_reg == CNT_MAX - 1'b1);
    wire port_init = cs_fall | rearm_end | rearm_16;
    wire [RB-1:0] init_word = rearm_end ? sar_next : result_out;

    ////////////////////////////////////////////////////////////////////////
    // Serial port: counters, address in, result out
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fall_cnt_reg <= '0;
            rise_cnt_reg <= '0;
            out_sr_reg <= '0;
            oe_reg <= 1'b0;
            addr_out <= '0;
            sample_on <= 1'b0;
        end else begin
            oe_reg <= cs_low;
            if (port_init) begin
                fall_cnt_reg <= '0;
                rise_cnt_reg <= '0;
                out_sr_reg <= init_word;
                sample_on <= 1'b0;
            end else begin
                if (fall_take) begin
                    fall_cnt_reg <= fall_cnt_reg + 1'b1;
                    // Zero fill leaves the line low from the tenth fall
                    out_sr_reg <= {out_sr_reg[RB-2:0], 1'b0};
                end
                if (rise_take) begin
                    rise_cnt_reg <= rise_cnt_reg + 1'b1;
                end
                if (addr_rise) begin
                    addr_out <= {addr_out[sadc_pkg::ADDR_BITS-2:0],
                        din_s2_reg};
                end
                if (acq_fall) begin
                    sample_on <= 1'b1;
                end else if (ten_fall) begin
                    sample_on <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer on the own clock, free of the shift clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cv_reg <= sadc_pkg::SADC_CV_IDLE;
            conv_cnt_reg <= '0;
            step_cnt_reg <= '0;
            held_reg <= '0;
            sar_reg <= '0;
            mask_reg <= '0;
            eoc_reg <= 1'b1;
            result_out <= '0;
            result_stb <= 1'b0;
        end else begin
            result_stb <= conv_end;
            case (cv_reg)
                sadc_pkg::SADC_CV_IDLE: begin
                    if (ten_fall) begin
                        cv_reg <= sadc_pkg::SADC_CV_RUN;
                        eoc_reg <= 1'b0;
                        held_reg <= code_in;
                        sar_reg <= '0;
                        mask_reg <= {1'b1, {(RB-1){1'b0}}};
                        conv_cnt_reg <= '0;
                        step_cnt_reg <= '0;
                    end
                end
                sadc_pkg::SADC_CV_RUN: begin
                    conv_cnt_reg <= conv_cnt_reg + 1'b1;
                    step_cnt_reg <= step_tick ? '0 : step_cnt_reg + 1'b1;
                    sar_reg <= sar_next;
                    if (step_tick) begin
                        mask_reg <= mask_reg >> 1;
                    end
                    if (abort_hit) begin
                        // Old result stays; done returns high at once
                        cv_reg <= sadc_pkg::SADC_CV_IDLE;
                        eoc_reg <= 1'b1;
                    end else if (conv_end) begin
                        result_out <= sar_next;
                        eoc_reg <= 1'b1;
                        cv_reg <= pend_end ? sadc_pkg::SADC_CV_PEND
                            : sadc_pkg::SADC_CV_IDLE;
                    end
                end
                sadc_pkg::SADC_CV_PEND: begin
                    if (port_init) begin
                        cv_reg <= sadc_pkg::SADC_CV_IDLE;
                    end
                end
                default: begin
                    cv_reg <= sadc_pkg::SADC_CV_IDLE;
                end
            endcase
        end
    end

    assign link.dout = out_sr_reg[RB-1];
    assign link.dout_oe = oe_reg;
    assign link.eoc = eoc_reg;
endmodule : sadc_dev
`default_nettype wire

// [core/sadc_host.sv]
// Host end: serial master, result FIFO and abort control
`timescale 1ns/10ps
`default_nettype none
module sadc_fifo #(
    parameter int WIDTH = sadc_pkg::RES_BITS,
    parameter int DEPTH = sadc_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("sadc_fifo: DEPTH must be a power of two, WIDTH positive");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg, rd_reg;
    logic [AW:0] cnt_reg;

    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire [AW:0] cnt_next = cnt_reg + {{AW{1'b0}}, push}
        - {{AW{1'b0}}, pop};

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wr_reg <= wr_reg + {{(AW-1){1'b0}}, push};
            rd_reg <= rd_reg + {{(AW-1){1'b0}}, pop};
            cnt_reg <= cnt_next;
            in_ready <= cnt_next != (AW+1)'(DEPTH);
            out_valid <= cnt_next != '0;
        end
    end

    assign out_data = mem[rd_reg];
endmodule : sadc_fifo

module sadc_host #(
    parameter int XFER_LEN = sadc_pkg::XFER_MAX,
    parameter int FIFO_DEPTH = sadc_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    sadc_if.host link,
    input wire logic cmd_valid,
    input wire logic [sadc_pkg::ADDR_BITS-1:0] cmd_addr,
    output logic cmd_ready,
    input wire logic abort_req,
    output logic res_valid,
    input wire logic res_ready,
    output logic [sadc_pkg::RES_BITS-1:0] res_data
);
    localparam int RB = sadc_pkg::RES_BITS;
    localparam int TW = sadc_pkg::TMR_W;
    localparam logic [4:0] LEN = 5'(XFER_LEN);
    localparam logic [4:0] TEN = 5'(sadc_pkg::CONV_FALL);
    localparam logic [TW-1:0] HALF_LAST = TW'(sadc_pkg::SCLK_HALF_CYC - 1);
    localparam logic [TW-1:0] SETUP_LAST = TW'(sadc_pkg::CS_SETUP_CYC - 1);
    localparam logic [TW-1:0] GUARD = TW'(sadc_pkg::EOC_GUARD_CYC);
    localparam logic [TW-1:0] ABORT_LIM = TW'(sadc_pkg::ABORT_CYC);

    // Lengths outside 10..16 or a clock too slow for the rise bound
    if (XFER_LEN < sadc_pkg::XFER_MIN || XFER_LEN > sadc_pkg::XFER_MAX
        || 2 * sadc_pkg::SCLK_HALF_CYC >= sadc_pkg::RISE_CYC)
    begin : g_bad_len
        $error("sadc_host: XFER_LEN must lie in 10..16");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic do_s1_reg, do_s2_reg, eoc_s1_reg, eoc_s2_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            do_s1_reg <= 1'b0;
            do_s2_reg <= 1'b0;
            eoc_s1_reg <= 1'b0;
            eoc_s2_reg <= 1'b0;
        end else begin
            do_s1_reg <= link.dout_line;
            do_s2_reg <= do_s1_reg;
            eoc_s1_reg <= link.eoc;
            eoc_s2_reg <= eoc_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer
    sadc_pkg::sadc_host_t st_reg;
    logic cs_n_reg, sclk_reg, din_reg, push_reg;
    logic [4:0] bit_reg;
    logic [TW-1:0] tmr_reg, ten_reg;
    logic [RB-1:0] rx_reg;
    logic [sadc_pkg::ADDR_BITS-1:0] addr_reg;
    logic fifo_ready;

    wire half_done = tmr_reg == HALF_LAST;
    wire last_fall = (bit_reg + 1'b1) == LEN;
    wire start_ok = cmd_valid & fifo_ready & eoc_s2_reg;
    wire abort_ok = abort_req & (ten_reg < ABORT_LIM);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= sadc_pkg::SADC_H_IDLE;
            cs_n_reg <= 1'b1;
            sclk_reg <= 1'b0;
            din_reg <= 1'b0;
            push_reg <= 1'b0;
            cmd_ready <= 1'b0;
            bit_reg <= '0;
            tmr_reg <= '0;
            ten_reg <= '0;
            rx_reg <= '0;
            addr_reg <= '0;
        end else begin
            cmd_ready <= 1'b0;
            push_reg <= 1'b0;
            tmr_reg <= tmr_reg + 1'b1;
            if (ten_reg != '1) begin
                ten_reg <= ten_reg + 1'b1;
            end
            case (st_reg)
                sadc_pkg::SADC_H_IDLE: begin
                    cs_n_reg <= 1'b1;
                    if (start_ok) begin
                        cmd_ready <= 1'b1;
                        addr_reg <= cmd_addr;
                        cs_n_reg <= 1'b0;
                        tmr_reg <= '0;
                        st_reg <= sadc_pkg::SADC_H_SETUP;
                    end
                end
                sadc_pkg::SADC_H_SETUP: begin
                    din_reg <= addr_reg[sadc_pkg::ADDR_BITS-1];
                    bit_reg <= '0;
                    if (tmr_reg == SETUP_LAST) begin
                        tmr_reg <= '0;
                        st_reg <= sadc_pkg::SADC_H_LOW;
                    end
                end
                sadc_pkg::SADC_H_LOW: begin
                    if (half_done) begin
                        sclk_reg <= 1'b1;
                        tmr_reg <= '0;
                        if (bit_reg < TEN) begin
                            rx_reg <= {rx_reg[RB-2:0], do_s2_reg};
                        end
                        st_reg <= sadc_pkg::SADC_H_HIGH;
                    end
                end
                sadc_pkg::SADC_H_HIGH: begin
                    if (half_done) begin
                        sclk_reg <= 1'b0;
                        tmr_reg <= '0;
                        // Data moves on the fall so it stands across the
                        // rise; both pins pass equal synchroniser delay
                        addr_reg <= addr_reg << 1;
                        din_reg <= addr_reg[sadc_pkg::ADDR_BITS-2];
                        bit_reg <= bit_reg + 1'b1;
                        if (bit_reg == TEN - 1'b1) begin
                            ten_reg <= '0;
                        end
                        // Clock runs on after the tenth fall, well inside
                        // the rise bound; one burst serves 16 clocks
                        st_reg <= last_fall ? sadc_pkg::SADC_H_END
                            : sadc_pkg::SADC_H_LOW;
                    end
                end
                sadc_pkg::SADC_H_END: begin
                    // Select rises between transfers, so any length fits
                    cs_n_reg <= 1'b1;
                    push_reg <= 1'b1;
                    tmr_reg <= '0;
                    st_reg <= sadc_pkg::SADC_H_WAIT;
                end
                sadc_pkg::SADC_H_WAIT: begin
                    if (abort_ok) begin
                        cs_n_reg <= 1'b0;
                        tmr_reg <= '0;
                        st_reg <= sadc_pkg::SADC_H_ABORT;
                    end else if (tmr_reg >= GUARD && eoc_s2_reg) begin
                        st_reg <= sadc_pkg::SADC_H_IDLE;
                    end
                end
                sadc_pkg::SADC_H_ABORT: begin
                    if (tmr_reg == SETUP_LAST) begin
                        cs_n_reg <= 1'b1;
                        st_reg <= sadc_pkg::SADC_H_IDLE;
                    end
                end
                default: begin
                    st_reg <= sadc_pkg::SADC_H_IDLE;
                end
            endcase
        end
    end

    sadc_fifo #(
        .WIDTH(RB),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(push_reg),
        .in_ready(fifo_ready),
        .in_data(rx_reg),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data)
    );

    assign link.cs_n = cs_n_reg;
    assign link.sclk = sclk_reg;
    assign link.din = din_reg;
endmodule : sadc_host
`default_nettype wire

// [tb/sadc_chk.sv]
// Link pin checker for the converter and host ends
`timescale 1ns/10ps
`default_nettype none
module sadc_chk #(
    parameter int CONV_CYC = 400,
    parameter int XFER_LEN = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic eoc
);
    localparam int CONV_HI = CONV_CYC + 2;
    localparam int CONV_LO = CONV_CYC - 2;
    localparam int RISE_LIM = 925;
    logic [4:0] fcnt_reg;
    logic [11:0] low_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    // Falls per frame, cleared while deselected
    always_ff @(posedge clk) begin
        if (sys_rst || cs_n) fcnt_reg <= 5'h00;
        else if ($fell(sclk)) fcnt_reg <= fcnt_reg + 5'h01;
    end
    always_ff @(posedge clk) begin
        if (sys_rst || eoc) low_reg <= 12'h000;
        else low_reg <= low_reg + 12'h001;
    end
    ////////////////////////////////////////////////////////////////////////
    property p_oe_off;
        cs_n [*4] |-> !dout_oe;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("data line driven while deselected");
    property p_oe_on;
        !cs_n [*5] |-> dout_oe;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("data line not driven while selected");
    property p_tail_zero;
        (!cs_n && fcnt_reg >= 5'h0a) [*5] |-> !dout;
    endproperty
    a_tail_zero: assert property (p_tail_zero)
        else $error("data line not low after tenth fall");
    property p_eoc_fall;
        $fell(eoc) |-> fcnt_reg == 5'h0a;
    endproperty
    a_eoc_fall: assert property (p_eoc_fall)
        else $error("done fell away from tenth fall");
    property p_eoc_due;
        $changed(fcnt_reg) && fcnt_reg == 5'h0a |-> ##[2:5] !eoc;
    endproperty
    a_eoc_due: assert property (p_eoc_due)
        else $error("done not low after tenth fall");
    property p_conv_max;
        $rose(eoc) |-> low_reg <= CONV_HI;
    endproperty
    a_conv_max: assert property (p_conv_max)
        else $error("conversion too long");
    property p_conv_full;
        $rose(eoc) && cs_n |-> low_reg >= CONV_LO;
    endproperty
    a_conv_full: assert property (p_conv_full)
        else $error("conversion ended early without abort");
    property p_frame_len;
        $rose(cs_n) |-> fcnt_reg == 5'h00 || fcnt_reg == XFER_LEN;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame clock count wrong");
    property p_sclk_half;
        $changed(sclk) |=> $stable(sclk) [*8];
    endproperty
    a_sclk_half: assert property (p_sclk_half)
        else $error("shift clock too fast");
    property p_rise_due;
        XFER_LEN > 10 && $changed(fcnt_reg) && fcnt_reg == 5'h0a
            |-> ##[1:RISE_LIM] $rose(sclk);
    endproperty
    a_rise_due: assert property (p_rise_due)
        else $error("no rise after tenth fall in time");
endmodule : sadc_chk
`default_nettype wire

// [tb/tb_top.sv]
// Bench joining both link ends: stream, full buffer and abort
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int CONV = 400;
    logic clk, sys_rst, cmd_valid, cmd_ready, abort_req, res_valid;
    logic res_ready, result_stb, sample_on, eoc_s;
    logic [3:0] cmd_addr, addr_out;
    logic [9:0] code_in, res_data, result_out;
    logic [9:0] last_code = 10'h000;
    logic [9:0] codes [4] = '{10'h3ff, 10'h000, 10'h2a5, 10'h15a};
    logic [9:0] exp_q [$];
    int n_fail = 0;
    int total_checks = 0;
    int stb_cnt = 0;
    sadc_if link_if ();
    assign eoc_s = link_if.eoc;
    sadc_dev #(.CONV_CYC(CONV)) sadc_dev_i (.clk(clk), .sys_rst(sys_rst),
        .link(link_if), .code_in(code_in), .addr_out(addr_out),
        .sample_on(sample_on), .result_out(result_out),
        .result_stb(result_stb));
    sadc_host #(.XFER_LEN(16), .FIFO_DEPTH(16)) sadc_host_i (.clk(clk),
        .sys_rst(sys_rst), .link(link_if), .cmd_valid(cmd_valid),
        .cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .abort_req(abort_req),
        .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
    sadc_chk #(.CONV_CYC(CONV), .XFER_LEN(16)) sadc_chk_i (.clk(clk),
        .sys_rst(sys_rst), .cs_n(link_if.cs_n), .sclk(link_if.sclk),
        .dout(link_if.dout), .dout_oe(link_if.dout_oe), .eoc(link_if.eoc));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [9:0] exp,
                         input logic [9:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // Bounded wait; a miss shows up in the caller's compare
    task automatic wait_for(ref logic sig, input logic lvl, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (sig !== lvl && n < 5000);
    endtask : wait_for
    task automatic xfer(input logic [3:0] addr, input logic [9:0] code,
                        input bit abort);
        int n;
        int s0;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_addr = addr;
        code_in = code;
        abort_req = abort;
        wait_for(cmd_ready, 1'b1, n);
        cmd_valid = 1'b0;
        s0 = stb_cnt;
        if (abort) begin
            wait_for(eoc_s, 1'b0, n);
            wait_for(eoc_s, 1'b1, n);
            check("abort early", 10'h001, {9'h000, n < CONV - 100});
            check("no strobe", 10'(s0), 10'(stb_cnt));
            check("result kept", last_code, result_out);
        end else begin
            wait_for(sample_on, 1'b1, n);
            check("address", {6'h00, addr}, {6'h00, addr_out});
            wait_for(sample_on, 1'b0, n);
            check("window", 10'h090, 10'(n));
            wait_for(result_stb, 1'b1, n);
            check("code", code, result_out);
            check("done high", 10'h001, {9'h000, eoc_s});
            last_code = code;
        end
    endtask : xfer
    ////////////////////////////////////////////////////////////////////////
    task automatic drain();
        int n;
        n = 0;
        @(negedge clk);
        res_ready = 1'b1;
        // Head is judged before the edge that pops it
        while (exp_q.size() > 0 && n < 5000) begin
            if (res_valid === 1'b1) begin
                check("read result", exp_q.pop_front(), res_data);
            end
            @(negedge clk);
            n++;
        end
        check("all read", 10'h000, 10'(exp_q.size()));
        @(negedge clk);
        check("buffer empty", 10'h000, {9'h000, res_valid});
        res_ready = 1'b0;
    endtask : drain
    task automatic test_fill();
        int n;
        logic [9:0] prev;
        for (int i = 0; i < 16; i++) begin
            prev = last_code;
            exp_q.push_back(prev);
            xfer(i[3:0], codes[i % 4], 1'b0);
        end
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_addr = 4'h5;
        wait_for(cmd_ready, 1'b1, n);
        cmd_valid = 1'b0;
        check("refused", 10'h000, {9'h000, cmd_ready});
        drain();
        $display("test fill done");
    endtask : test_fill
    task automatic test_abort();
        exp_q.push_back(last_code);
        xfer(4'h1, 10'h0ff, 1'b1);
        exp_q.push_back(last_code);
        xfer(4'h2, 10'h1c3, 1'b0);
        exp_q.push_back(last_code);
        xfer(4'h3, 10'h200, 1'b0);
        drain();
        $display("test abort done");
    endtask : test_abort
    ////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (result_stb === 1'b1) stb_cnt++;
    end
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        $display("watchdog expired");
        give_verdict();
    end
    initial begin
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_addr = 4'h0;
        abort_req = 1'b0;
        res_ready = 1'b0;
        code_in = 10'h000;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        test_fill();
        test_abort();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
